// [bench/gpt_top_tb_top.sv]
// Purpose: self-checking bench of the general purpose timer set
// Assumes: registered axi4-lite slave, timer t at t*0x10 (+0 ctrl, +4 count, +8 period)
// Notes:   bus tasks first, then timer scenarios checked against worked-out values
`timescale 1ns/1ps
`include "gpt_params.svh"

module gpt_top_tb_top
  import gpt_pkg::*;
;
  // clock, reset, pins and device state
  logic                   clk, rst, primary_count_pin, cpu_idle;
  logic [3:0]             paired_count_pin;
  // axi4-lite bus
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                   s_axi_rvalid, s_axi_rready;
  logic [`GPT_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  // events and bench bookkeeping
  logic [4:0]             timer_flag;
  logic [1:0]             dma_trigger;
  logic                   adc_trigger;
  int                     n_fail, n_compared, cyc, adc_n, dma_n;
  logic [31:0]            d, e, a0, d0;
  logic [15:0]            msk [5] = '{16'hA076, 16'hA07A, 16'hA072, 16'hA07A, 16'hA072};

  gpt_top uut (
    .clk(clk), .rst(rst), .primary_count_pin(primary_count_pin),
    .paired_count_pin(paired_count_pin), .cpu_idle(cpu_idle),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .timer_flag(timer_flag),
    .dma_trigger(dma_trigger), .adc_trigger(adc_trigger));

  // verdict and end of run, also reached by the watchdog
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // exact compare, an unknown matches only an unknown in the same bit
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // compare against a window, for counts that depend on bus latency
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er = 2'b00);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {16'h0000, v};
    s_axi_wstrb   <= 4'hF;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask : wr

  // one read, response code checked, data returned
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'b00);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    @(posedge clk);
    while (s_axi_arready !== 1'b1) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    v = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask : rd

  // one rising then falling edge on the count pin of timer t
  task automatic pulse(input int t);
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk);
      if (t == 0) primary_count_pin <= k[0];
      else paired_count_pin[t-1] <= k[0];
      repeat (3) @(posedge clk);
    end
  endtask : pulse

  // free running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog and trigger pulse counters
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (adc_trigger === 1'b1) adc_n <= adc_n + 1;
    if (dma_trigger[1] === 1'b1) dma_n <= dma_n + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    {n_fail, n_compared, cyc, adc_n, dma_n} = '0;
    {rst, primary_count_pin, paired_count_pin, cpu_idle} = 7'h40;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rd(8'h08, d);
    chk(d, 32'h0000_FFFF);
    rd(8'h60, d, 2'b10);
    chk(d, 32'h0000_0000);
    wr(8'h60, 16'h1234, 2'b10);
    // writable control bits of each timer kind
    for (int t = 0; t < 5; t++) begin
      wr(8'(t * 16), 16'hFFFF);
      rd(8'(t * 16), d);
      chk(d, {16'h0000, msk[t]});
      wr(8'(t * 16), 16'h0000);
    end
    // period match wraps and flags, stop freezes count
    wr(8'h08, 16'h0002);
    wr(8'h50, 16'h001F);
    wr(8'h00, 16'h8000);
    repeat (6) @(posedge clk);
    chk(32'(timer_flag[0]), 32'h0000_0001);
    wr(8'h00, 16'h0000);
    rd(8'h04, d);
    chk_rng(d, 32'h0000_0000, 32'h0000_0002);
    repeat (10) @(posedge clk);
    rd(8'h04, e);
    chk(e, d);
    // idle stop halts, clear idle stop keeps counting
    wr(8'h08, 16'hFFFF);
    cpu_idle <= 1'b1;
    wr(8'h00, 16'hA000);
    rd(8'h04, d);
    repeat (10) @(posedge clk);
    rd(8'h04, e);
    chk(e, d);
    wr(8'h00, 16'h8000);
    rd(8'h04, d);
    repeat (10) @(posedge clk);
    rd(8'h04, e);
    chk_rng(e - d, 32'h0000_000A, 32'h0000_0014);
    cpu_idle <= 1'b0;
    wr(8'h00, 16'h0000);
    // prescale ratios on a lower half
    for (int p = 0; p < 4; p++) begin
      wr(8'h34, 16'h0000);
      wr(8'h30, 16'(16'h8000 | (p << 4)));
      repeat (1024) @(posedge clk);
      wr(8'h30, 16'h0000);
      rd(8'h34, d);
      chk_rng(d, (1024 >> (3 * p - (p == 3))) - 1, (1040 >> (3 * p - (p == 3))) + 1);
    end
    // external pin counting on every timer, gate bit set but ignored
    for (int i = 0; i < 6; i++) begin
      automatic int t = (i == 5) ? 0 : i;
      wr(8'(t * 16 + 4), 16'h0000);
      wr(8'(t * 16), (i == 5) ? 16'h8042 : 16'h8046);
      repeat (5) pulse(t);
      repeat (8) @(posedge clk);
      rd(8'(t * 16 + 4), d);
      chk(d, 32'h0000_0005);
      wr(8'(t * 16), 16'h0000);
    end
    // gated accumulation on timer 1, flag on gate fall
    wr(8'h14, 16'h0000);
    wr(8'h50, 16'h001F);
    wr(8'h10, 16'h8040);
    @(posedge clk);
    paired_count_pin[0] <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(timer_flag[1]), 32'h0000_0000);
    paired_count_pin[0] <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(timer_flag[1]), 32'h0000_0001);
    rd(8'h14, d);
    chk_rng(d, 32'h0000_0012, 32'h0000_0016);
    wr(8'h10, 16'h0000);
    // joined pair carries into the upper half, upper control left off
    wr(8'h14, 16'hFFFE);
    wr(8'h24, 16'h0000);
    wr(8'h10, 16'h8008);
    repeat (10) @(posedge clk);
    wr(8'h10, 16'h0000);
    rd(8'h24, d);
    chk(d, 32'h0000_0001);
    // joined period upper word nonzero: no match within the run
    wr(8'h14, 16'h0000);
    wr(8'h24, 16'h0000);
    wr(8'h18, 16'h0005);
    wr(8'h28, 16'h0001);
    wr(8'h50, 16'h001F);
    wr(8'h10, 16'h8008);
    repeat (20) @(posedge clk);
    wr(8'h10, 16'h0000);
    chk(32'(timer_flag), 32'h0000_0000);
    // joined period of five: flag and triggers through the upper half
    wr(8'h14, 16'h0000);
    wr(8'h28, 16'h0000);
    a0 = adc_n;
    d0 = dma_n;
    wr(8'h10, 16'h8008);
    repeat (20) @(posedge clk);
    wr(8'h10, 16'h0000);
    chk(32'(timer_flag), 32'h0000_0004);
    chk_rng(adc_n - a0, 32'h0000_0001, 32'h0000_0006);
    chk_rng(dma_n - d0, 32'h0000_0001, 32'h0000_0006);
    // joined pair in idle obeys only the upper idle-stop bit
    wr(8'h18, 16'hFFFF);
    cpu_idle <= 1'b1;
    wr(8'h20, 16'h2000);
    wr(8'h10, 16'h8008);
    rd(8'h14, d);
    repeat (10) @(posedge clk);
    rd(8'h14, e);
    chk(e, d);
    wr(8'h20, 16'h0000);
    rd(8'h14, d);
    repeat (10) @(posedge clk);
    rd(8'h14, e);
    chk_rng(e - d, 32'h0000_000A, 32'h0000_0014);
    cpu_idle <= 1'b0;
    wr(8'h10, 16'h0000);
    finish_test();
  end
endmodule : gpt_top_tb_top

// [hdl/gpt_params.svh]
// Purpose: constants of the general purpose timer set
// Assumes: included by the package and the top module
// Notes:   word offsets, control bit positions, prescale limits, reset values
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH

`define GPT_NUM_TMR      5
`define GPT_ADDR_W       8
// register map, one window of four words per timer
`define GPT_OFS_CTRL     2'h0
`define GPT_OFS_COUNT    2'h1
`define GPT_OFS_PERIOD   2'h2
`define GPT_STATUS_IDX   3'h5
`define GPT_STATUS_OFS   2'h0
// control bit positions
`define GPT_B_RUN        15
`define GPT_B_IDLE       13
`define GPT_B_GATE       6
`define GPT_B_PS_HI      5
`define GPT_B_PS_LO      4
`define GPT_B_JOIN       3
`define GPT_B_SYNC       2
`define GPT_B_SRC        1
// writable bits per timer kind, other bits read as zero
`define GPT_MASK_PRIM    16'hA076
`define GPT_MASK_LOWER   16'hA07A
`define GPT_MASK_UPPER   16'hA072
// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GPT_PS_LIM_1     8'h00
`define GPT_PS_LIM_8     8'h07
`define GPT_PS_LIM_64    8'h3F
`define GPT_PS_LIM_256   8'hFF
// reset values
`define GPT_CTRL_RST     16'h0000
`define GPT_PERIOD_RST   16'hFFFF
`define GPT_COUNT_RST    16'h0000
// bus responses
`define GPT_RESP_OKAY    2'b00
`define GPT_RESP_SLVERR  2'b10

`endif

// [hdl/gpt_pkg.sv]
// Purpose: types of the general purpose timer set
// Assumes: gpt_params.svh supplies the sizes
// Notes:   the whole module state is one packed struct
`include "gpt_params.svh"

package gpt_pkg;

  // primary timer operating modes, {source, gate or sync}
  typedef enum logic [1:0] {
    GPT_M_TIMER = 2'b00,
    GPT_M_GATED = 2'b01,
    GPT_M_ASYNC = 2'b10,
    GPT_M_SYNC  = 2'b11
  } gpt_mode_e;

  typedef logic [`GPT_NUM_TMR-1:0] gpt_vec_t;

  typedef struct packed {
    logic [`GPT_NUM_TMR-1:0][15:0] ctrl;     // control registers
    logic [`GPT_NUM_TMR-1:0][15:0] cnt;      // count registers
    logic [`GPT_NUM_TMR-1:0][15:0] per;      // period registers
    logic [`GPT_NUM_TMR-1:0][7:0]  psc;      // prescaler counters
    gpt_vec_t                      pin_prev; // pin one cycle ago
    gpt_vec_t                      sync1;    // level synchroniser stage 1
    gpt_vec_t                      sync2;    // level synchroniser stage 2
    gpt_vec_t                      sync3;    // stage 2 delayed, edge detect
    gpt_vec_t                      dly1;     // tick synchroniser stage 1
    gpt_vec_t                      dly2;     // tick synchroniser stage 2
    gpt_vec_t                      flag;     // sticky interrupt flags
    logic                          adc_trig; // conversion start pulse
    logic [1:0]                    dma_trig; // dma request pulses
    logic                          aw_rdy;
    logic                          w_rdy;
    logic                          aw_have;
    logic                          w_have;
    logic [`GPT_ADDR_W-1:0]        aw_addr;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          ar_rdy;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } gpt_state_s;

endpackage : gpt_pkg

// [hdl/gpt_top.sv]
// Purpose: five 16-bit timers, two joinable pairs, AXI4-Lite registers
// Assumes: clk is the instruction clock, pins synchronous to clk
// Notes:   timer 0 primary, 1 and 3 lower halves, 2 and 4 upper halves
//
// Summary of operation
// - primary 16-bit timer, counts 32 kHz oscillator
// - timer modes internal clock, counter modes pin
// - primary mode from source, sync, gate bits
// - primary sync bit: synchronise after prescaler
// - lower halves synchronise after prescaler
// - upper halves synchronise before prescaler
// - prescale 1:1, 1:8, 1:64, 1:256
// - run bit starts and stops timer
// - idle-stop bit halts timer in idle
// - gate bit ignored with external source
// - primary source bit selects pin rising edges
// - paired timers: timer, gated, sync counter
// - paired internal clock is oscillator over two
// - join bit forms 32-bit counter, upper msw
// - only timers one-two and three-four join
// - joined pair uses lower control, upper idle
// - joined pair flags through upper half
// - joined period: upper msw, lower lsw
// - joined count: upper msw, lower lsw
// - only timers one and two request dma
// - upper half timer two triggers conversion
`timescale 1ns/1ps
`include "gpt_params.svh"

module gpt_top
  import gpt_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // count and gate pins, device state
  input  wire logic                   primary_count_pin,
  input  wire logic [3:0]             paired_count_pin,
  input  wire logic                   cpu_idle,
  // axi4-lite write address and data
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`GPT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // axi4-lite write response
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  // axi4-lite read
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`GPT_ADDR_W-1:0] s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  // events
  output logic [`GPT_NUM_TMR-1:0]     timer_flag,
  output logic [1:0]                  dma_trigger,
  output logic                        adc_trigger
);

  gpt_state_s                   q;        // registered state
  gpt_state_s                   n;        // next state
  logic [`GPT_NUM_TMR-1:0]      pin_in;   // pin per timer
  logic [`GPT_NUM_TMR-1:0]      run_w;    // timer advances
  logic [`GPT_NUM_TMR-1:0]      ext_w;    // external source chosen
  logic [`GPT_NUM_TMR-1:0]      gated_w;  // gated accumulation active
  logic [`GPT_NUM_TMR-1:0]      raw_w;    // prescaler input pulse
  logic [`GPT_NUM_TMR-1:0]      hit_w;    // prescaler output pulse
  logic [`GPT_NUM_TMR-1:0]      tick_w;   // count pulse after sync
  logic [`GPT_NUM_TMR-1:0]      fall_w;   // gate falling edge
  logic [`GPT_NUM_TMR-1:0]      join_w;   // lower half of joined pair
  logic [`GPT_NUM_TMR-1:0][7:0] lim_w;    // prescaler terminal count
  logic [`GPT_NUM_TMR-1:0]      evt_c;    // flag set events this cycle
  logic                         wr_en;    // register write this cycle
  logic [31:0]                  rd_val;   // read mux output

  assign pin_in = {paired_count_pin, primary_count_pin};
  assign wr_en  = q.aw_have & q.w_have & ~q.bvalid;

  // per-timer decode of the effective control word
  genvar g;
  generate
    for (g = 0; g < `GPT_NUM_TMR; g++) begin : g_tmr
      localparam bit IS_LOW = (g % 2) == 1;  // lower halves 1 and 3
      localparam bit IS_UP  = (g != 0) && (g % 2) == 0;
      localparam int LO     = IS_UP ? g - 1 : g;
      localparam int HI     = IS_LOW ? g + 1 : g;
      logic [15:0] ce;      // control that governs this timer
      logic        idl;     // idle-stop bit of timer HI, governs a joined pair
      logic        joined;  // pair joined
      logic        edge_in; // external rising edge
      gpt_mode_e   mode;

      assign joined = (IS_LOW || IS_UP) ? q.ctrl[LO][`GPT_B_JOIN] : 1'b0;
      // a lone upper half obeys its own control, a joined one the lower's
      assign ce     = (IS_UP && joined) ? q.ctrl[LO] : q.ctrl[g];
      assign idl    = q.ctrl[HI][`GPT_B_IDLE];
      assign mode   = gpt_mode_e'({ce[`GPT_B_SRC],
                                   ce[`GPT_B_SRC] ? ce[`GPT_B_SYNC] : ce[`GPT_B_GATE]});
      // upper halves synchronise the pin level before the prescaler
      assign edge_in = IS_UP ? (q.sync2[g] & ~q.sync3[g])
                             : (pin_in[g] & ~q.pin_prev[g]);
      // run bit and idle-stop, upper half of a joined pair stands idle
      assign run_w[g]   = ce[`GPT_B_RUN] & ~(cpu_idle & (joined ? idl : q.ctrl[g][`GPT_B_IDLE]))
                          & ~(IS_UP && joined);
      assign ext_w[g]   = ce[`GPT_B_SRC];
      assign gated_w[g] = (mode == GPT_M_GATED);
      assign join_w[g]  = IS_LOW && joined;
      // internal source counts every instruction clock, in gated mode only while the pin is high
      assign raw_w[g]   = run_w[g] & (ext_w[g] ? edge_in
                                     : (~gated_w[g] | pin_in[g]));
      assign fall_w[g]  = run_w[g] & gated_w[g] & q.pin_prev[g] & ~pin_in[g];
      always_comb begin
        case (ce[`GPT_B_PS_HI:`GPT_B_PS_LO])
          2'b11:   lim_w[g] = `GPT_PS_LIM_256;
          2'b10:   lim_w[g] = `GPT_PS_LIM_64;
          2'b01:   lim_w[g] = `GPT_PS_LIM_8;
          default: lim_w[g] = `GPT_PS_LIM_1;
        endcase
      end
      assign hit_w[g]  = raw_w[g] & (q.psc[g] == lim_w[g]);
      // primary with sync and lower halves on an external source pass the tick through two stages
      assign tick_w[g] = (ext_w[g] && (IS_LOW || (g == 0 && mode == GPT_M_SYNC)))
                         ? q.dly2[g] & run_w[g] : hit_w[g];
    end
  endgenerate

  // merge a write into a 16-bit register under byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sb);
    merge16 = {sb[1] ? wd[15:8] : old[15:8], sb[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // writable bit mask by timer kind
  function automatic logic [15:0] ctrl_mask(input int idx);
    if (idx == 0) begin
      ctrl_mask = `GPT_MASK_PRIM;
    end else if (idx % 2 == 1) begin
      ctrl_mask = `GPT_MASK_LOWER;
    end else begin
      ctrl_mask = `GPT_MASK_UPPER;
    end
  endfunction : ctrl_mask

  // read mux, unmapped words read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr[6:4] < 3'(`GPT_NUM_TMR)) begin
      case (s_axi_araddr[3:2])
        `GPT_OFS_CTRL:   rd_val = {16'h0000, q.ctrl[s_axi_araddr[6:4]]};
        `GPT_OFS_COUNT:  rd_val = {16'h0000, q.cnt[s_axi_araddr[6:4]]};
        `GPT_OFS_PERIOD: rd_val = {16'h0000, q.per[s_axi_araddr[6:4]]};
        default:         rd_val = 32'h0000_0000;
      endcase
    end else if (s_axi_araddr[6:4] == `GPT_STATUS_IDX
                 && s_axi_araddr[3:2] == `GPT_STATUS_OFS) begin
      rd_val = {27'h000_0000, q.flag};
    end
  end

  // next state: bus handshakes, prescalers, counters, flags
  always_comb begin
    logic [31:0] c32;   // joined count
    logic [31:0] p32;   // joined period
    logic [2:0]  widx;  // written timer index
    logic        wmap;  // write hits a register
    c32   = 32'h0000_0000;
    p32   = 32'h0000_0000;
    widx  = q.aw_addr[6:4];
    wmap  = 1'b0;
    n     = q;
    evt_c = '0;
    // write address and data are taken in either order
    if (s_axi_awvalid && q.aw_rdy) begin
      n.aw_addr = s_axi_awaddr;
      n.aw_have = 1'b1;
      n.aw_rdy  = 1'b0;
    end
    if (s_axi_wvalid && q.w_rdy) begin
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
      n.w_have = 1'b1;
      n.w_rdy  = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy  = 1'b1;
    end
    // read answered one cycle after the address is taken
    if (s_axi_arvalid && q.ar_rdy) begin
      n.rdata  = rd_val;
      n.rresp  = (s_axi_araddr[6:4] < `GPT_STATUS_IDX && s_axi_araddr[3:2] != 2'h3) ||
                 (s_axi_araddr[6:4] == `GPT_STATUS_IDX && s_axi_araddr[3:2] == `GPT_STATUS_OFS)
                 ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
      n.rvalid = 1'b1;
      n.ar_rdy = 1'b0;
    end else if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end
    // pin sampling and synchroniser stages
    n.pin_prev = pin_in;
    n.sync1    = pin_in;
    n.sync2    = q.sync1;
    n.sync3    = q.sync2;
    n.dly1     = hit_w;
    n.dly2     = q.dly1;
    for (int i = 0; i < `GPT_NUM_TMR; i++) begin
      // prescaler divides the selected input
      if (raw_w[i]) begin
        n.psc[i] = hit_w[i] ? 8'h00 : q.psc[i] + 8'h01;
      end
      if (fall_w[i]) begin
        evt_c[join_w[i] ? i + 1 : i] = 1'b1;
      end
      if (tick_w[i] && join_w[i]) begin
        // joined pair counts as one 32-bit value
        c32 = {q.cnt[i+1], q.cnt[i]};
        p32 = {q.per[i+1], q.per[i]};
        if (c32 == p32) begin
          c32 = 32'h0000_0000;
          evt_c[i+1] = 1'b1;
        end else begin
          c32 = c32 + 32'h0000_0001;
        end
        n.cnt[i+1] = c32[31:16];
        n.cnt[i]   = c32[15:0];
      end else if (tick_w[i]) begin
        if (q.cnt[i] == q.per[i]) begin
          n.cnt[i] = `GPT_COUNT_RST;
          evt_c[i] = 1'b1;
        end else begin
          n.cnt[i] = q.cnt[i] + 16'h0001;
        end
      end
    end
    // register write, software count write clears the prescaler
    if (wr_en) begin
      n.bvalid  = 1'b1;
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      for (int i = 0; i < `GPT_NUM_TMR; i++) begin
        if (widx == 3'(i)) begin
          case (q.aw_addr[3:2])
            `GPT_OFS_CTRL: begin
              n.ctrl[i] = merge16(q.ctrl[i], q.w_data, q.w_strb) & ctrl_mask(i);
              wmap      = 1'b1;
            end
            `GPT_OFS_COUNT: begin
              n.cnt[i] = merge16(q.cnt[i], q.w_data, q.w_strb);
              n.psc[i] = 8'h00;
              wmap     = 1'b1;
            end
            `GPT_OFS_PERIOD: begin
              n.per[i] = merge16(q.per[i], q.w_data, q.w_strb);
              wmap     = 1'b1;
            end
            default: wmap = 1'b0;
          endcase
        end
      end
      if (widx == `GPT_STATUS_IDX && q.aw_addr[3:2] == `GPT_STATUS_OFS) begin
        wmap = 1'b1;
        if (q.w_strb[0]) begin
          n.flag = q.flag & ~q.w_data[`GPT_NUM_TMR-1:0];                // write one clears
        end
      end
      n.bresp = wmap ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
    end
    // a set in the same cycle as a clear wins
    n.flag     = n.flag | evt_c;
    n.dma_trig = {evt_c[2], evt_c[1]};
    n.adc_trig = evt_c[2];
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q        <= '0;
      q.per    <= {`GPT_NUM_TMR{`GPT_PERIOD_RST}};
      q.aw_rdy <= 1'b1;
      q.w_rdy  <= 1'b1;
      q.ar_rdy <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready  = q.w_rdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign timer_flag    = q.flag;
  assign dma_trigger   = q.dma_trig;
  assign adc_trigger   = q.adc_trig;

  // checks on the timer behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_stop_holds;
    (!q.ctrl[0][`GPT_B_RUN] && !wr_en) |=> $stable(q.cnt[0]);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("stopped primary timer changed count");

  property p_idle_holds;
    (q.ctrl[0][`GPT_B_IDLE] && cpu_idle && !wr_en) |=> $stable(q.cnt[0]);
  endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("primary timer counted in idle with idle-stop set");

  property p_period_wrap;
    (tick_w[0] && q.cnt[0] == q.per[0] && !wr_en) |=> (q.cnt[0] == 16'h0000 && q.flag[0]);
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("period match did not clear count and set flag");

  property p_prescale_8;
    (run_w[3] && !ext_w[3] && !gated_w[3] && lim_w[3] == `GPT_PS_LIM_8
     && q.psc[3] == 8'h00 && !wr_en) |=> (q.psc[3] == 8'h01 && !tick_w[3]);
  endproperty
  a_prescale_8: assert property (p_prescale_8)
    else $error("prescaler 1:8 did not step");

  property p_join_carry;
    (join_w[1] && tick_w[1] && q.cnt[1] == 16'hFFFF
     && {q.cnt[2], q.cnt[1]} != {q.per[2], q.per[1]} && !wr_en)
    |=> (q.cnt[1] == 16'h0000 && q.cnt[2] == $past(q.cnt[2]) + 16'h0001);
  endproperty
  a_join_carry: assert property (p_join_carry)
    else $error("joined pair did not carry into upper half");

  property p_join_lower_flag;
    (join_w[1] && !q.flag[1]) |=> !q.flag[1];
  endproperty
  a_join_lower_flag: assert property (p_join_lower_flag)
    else $error("joined pair raised the lower half flag");

  property p_lower_sync;
    (run_w[1] && ext_w[1] && lim_w[1] == `GPT_PS_LIM_1 && raw_w[1] && !wr_en)
    |=> !wr_en ##1 (tick_w[1] || !run_w[1]);
  endproperty
  a_lower_sync: assert property (p_lower_sync)
    else $error("lower half tick not two cycles after pin edge");

  property p_trigger_out;
    evt_c[2] |=> (adc_trigger && dma_trigger[1]);
  endproperty
  a_trigger_out: assert property (p_trigger_out)
    else $error("upper half event did not raise triggers");

  property p_gate_fall;
    (fall_w[1] && !join_w[1]) |=> q.flag[1];
  endproperty
  a_gate_fall: assert property (p_gate_fall)
    else $error("gate falling edge did not set flag");

endmodule : gpt_top
